/* hw/tod_counter_regs.svh */
// constants for the line frequency time of day counter
`ifndef TOD_COUNTER_REGS_SVH
`define TOD_COUNTER_REGS_SVH
// What this block does
// - one tick is counted for every falling edge of the conditioned line input, except one that a load taken in idle drops.
// - the line input passes a hysteresis filter so noise makes no extra ticks.
// - time is four counters, hours to ticks, and a tick bumps the ticks first.
// - each bumped counter is compared with its own modulus.
// - a counter still below its modulus ends the update for that tick.
// - a counter reaching its modulus clears and carries into the next one.
// - moduli are 60 ticks, 60 seconds, 60 minutes and 13 hours in 12-hour mode.
// - the tick modulus can be 50 for a 50 Hz supply.
// - in 24-hour mode the hours modulus is 24, counting 0 to 23.
// - in 12-hour mode an hours wrap to zero is bumped once more to one.
// - an hours overflow carries nowhere further.
`define TOD_MOD_TICKS_60HZ 6'h3c
`define TOD_MOD_TICKS_50HZ 6'h32
`define TOD_MOD_SECONDS 6'h3c
`define TOD_MOD_MINUTES 6'h3c
`define TOD_MOD_HOURS_12 6'h0d
`define TOD_MOD_HOURS_24 6'h18
`define TOD_FILTER_LEN 4
`define TOD_COUNT_RESET 6'h00
`define TOD_LINE_IDLE 1'b1
`endif

/* hw/tod_counter_pkg.sv */
// types for the line frequency time of day counter
package tod_counter_pkg;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_BUMP = 3'b001,
        ST_CHECK = 3'b011,
        ST_FIX12 = 3'b010
    } update_state_e;
    typedef logic [5:0] count_t;
endpackage

/* hw/line_edge_filter.sv */
// hysteresis filter and falling edge detector for the line input
`timescale 1ns/1ps
`include "tod_counter_regs.svh"
module line_edge_filter #(
    parameter int FILTER_LEN = `TOD_FILTER_LEN
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_in,
    output logic fall_tick
);
    localparam int CW = $clog2(FILTER_LEN + 1);
    logic sync1_reg, sync2_reg, sync1_next, sync2_next;
    logic level_reg, level_next;
    logic [CW-1:0] cnt_reg, cnt_next;
    logic fall_reg, fall_next;

    always_comb begin
        sync1_next = line_in;
        sync2_next = sync1_reg;
        level_next = level_reg;
        cnt_next = cnt_reg;
        fall_next = 1'b0;
        // level flips only after FILTER_LEN samples agree
        if (sync2_reg == level_reg) begin
            cnt_next = '0;
        end else if (cnt_reg == CW'(FILTER_LEN - 1)) begin
            cnt_next = '0;
            level_next = sync2_reg;
            fall_next = level_reg & ~sync2_reg;
        end else begin
            cnt_next = cnt_reg + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= `TOD_LINE_IDLE;
            sync2_reg <= `TOD_LINE_IDLE;
            level_reg <= `TOD_LINE_IDLE;
            cnt_reg <= '0;
            fall_reg <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            level_reg <= level_next;
            cnt_reg <= cnt_next;
            fall_reg <= fall_next;
        end
    end

    assign fall_tick = fall_reg;
endmodule

/* hw/line_frequency_time_of_day_counter.sv */
// time of day counter advanced by filtered mains edges
`timescale 1ns/1ps
`include "tod_counter_regs.svh"
module line_frequency_time_of_day_counter #(
    parameter int FILTER_LEN = `TOD_FILTER_LEN
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic line_in,
    input wire logic mode_50hz,
    input wire logic mode_24h,
    input wire logic load,
    input wire logic [5:0] load_hours,
    input wire logic [5:0] load_minutes,
    input wire logic [5:0] load_seconds,
    input wire logic [5:0] load_ticks,
    output logic [5:0] hours_count,
    output logic [5:0] minutes_count,
    output logic [5:0] seconds_count,
    output logic [5:0] ticks_count,
    output logic busy,
    output logic tick_seen
);
    // ----------------------------------------
    // line conditioning
    // ----------------------------------------
    logic fall_tick;
    logic m50_s1_reg, m50_s2_reg, m24_s1_reg, m24_s2_reg;

    line_edge_filter #(
        .FILTER_LEN(FILTER_LEN)
    ) u_filter (
        .clk(clk),
        .rst_n(rst_n),
        .line_in(line_in),
        .fall_tick(fall_tick)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            m50_s1_reg <= 1'b0;
            m50_s2_reg <= 1'b0;
            m24_s1_reg <= 1'b0;
            m24_s2_reg <= 1'b0;
        end else begin
            m50_s1_reg <= mode_50hz;
            m50_s2_reg <= m50_s1_reg;
            m24_s1_reg <= mode_24h;
            m24_s2_reg <= m24_s1_reg;
        end
    end

    // ----------------------------------------
    // counter chain, index 0 hours .. 3 ticks
    // ----------------------------------------
    tod_counter_pkg::count_t cnt_reg [4];
    tod_counter_pkg::count_t cnt_next [4];
    tod_counter_pkg::count_t counter_moduli [4];
    tod_counter_pkg::update_state_e state_reg, state_next;
    logic [1:0] idx_reg, idx_next;
    logic pend_reg, pend_next;
    logic seen_reg, seen_next;
    tod_counter_pkg::count_t bumped;

    always_comb begin
        counter_moduli[0] = m24_s2_reg ? `TOD_MOD_HOURS_24
                                       : `TOD_MOD_HOURS_12;
        counter_moduli[1] = `TOD_MOD_MINUTES;
        counter_moduli[2] = `TOD_MOD_SECONDS;
        counter_moduli[3] = m50_s2_reg ? `TOD_MOD_TICKS_50HZ
                                       : `TOD_MOD_TICKS_60HZ;
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            cnt_next[i] = cnt_reg[i];
        end
        state_next = state_reg;
        idx_next = idx_reg;
        pend_next = pend_reg;
        seen_next = fall_tick;
        bumped = cnt_reg[idx_reg] + 6'h01;
        // a tick arriving mid-update waits, but a load taken in ST_IDLE drops it
        if (fall_tick && state_reg != tod_counter_pkg::ST_IDLE) begin
            pend_next = 1'b1;
        end
        case (state_reg)
            tod_counter_pkg::ST_IDLE: begin
                if (load) begin
                    cnt_next[0] = load_hours;
                    cnt_next[1] = load_minutes;
                    cnt_next[2] = load_seconds;
                    cnt_next[3] = load_ticks;
                    pend_next = 1'b0;
                end else if (fall_tick || pend_reg) begin
                    pend_next = 1'b0;
                    idx_next = 2'd3;
                    state_next = tod_counter_pkg::ST_BUMP;
                end
            end
            tod_counter_pkg::ST_BUMP: begin
                cnt_next[idx_reg] = bumped;
                state_next = tod_counter_pkg::ST_CHECK;
            end
            tod_counter_pkg::ST_CHECK: begin
                if (cnt_reg[idx_reg] < counter_moduli[idx_reg]) begin
                    state_next = tod_counter_pkg::ST_IDLE;
                end else begin
                    cnt_next[idx_reg] = 6'h00;
                    if (idx_reg != 2'd0) begin
                        idx_next = idx_reg - 2'd1;
                        state_next = tod_counter_pkg::ST_BUMP;
                    end else if (!m24_s2_reg) begin
                        state_next = tod_counter_pkg::ST_FIX12;
                    end else begin
                        state_next = tod_counter_pkg::ST_IDLE;
                    end
                end
            end
            tod_counter_pkg::ST_FIX12: begin
                cnt_next[0] = cnt_reg[0] + 6'h01;
                state_next = tod_counter_pkg::ST_IDLE;
            end
            default: begin
                state_next = tod_counter_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 4; i++) begin
                cnt_reg[i] <= `TOD_COUNT_RESET;
            end
            state_reg <= tod_counter_pkg::ST_IDLE;
            idx_reg <= 2'd3;
            pend_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                cnt_reg[i] <= cnt_next[i];
            end
            state_reg <= state_next;
            idx_reg <= idx_next;
            pend_reg <= pend_next;
            seen_reg <= seen_next;
        end
    end

    assign hours_count = cnt_reg[0];
    assign minutes_count = cnt_reg[1];
    assign seconds_count = cnt_reg[2];
    assign ticks_count = cnt_reg[3];
    assign busy = (state_reg != tod_counter_pkg::ST_IDLE) | pend_reg;
    assign tick_seen = seen_reg;
endmodule

/* verification/mains_src.sv */
// mains waveform source for the line input
`timescale 1ns/1ps
module mains_src #(parameter int HALF = 32) (
    input wire logic clk,
    output logic line_out
);
    initial line_out = 1'b1;
    task automatic mains_cycle(input bit bounce);
        @(negedge clk) line_out <= 1'b0;
        @(negedge clk) line_out <= bounce;
        @(negedge clk) line_out <= 1'b0;
        repeat (HALF) @(negedge clk);
        line_out <= 1'b1;
        repeat (HALF) @(negedge clk);
    endtask
    // two clean falls eight cycles apart, second lands mid-carry
    task automatic mains_burst();
        @(negedge clk) line_out <= 1'b0;
        repeat (4) @(negedge clk);
        line_out <= 1'b1;
        repeat (4) @(negedge clk);
        line_out <= 1'b0;
        repeat (HALF) @(negedge clk);
        line_out <= 1'b1;
        repeat (HALF) @(negedge clk);
    endtask
endmodule

/* verification/tod_props.sv */
// assertions on the counter ports
`timescale 1ns/1ps
module tod_props #(parameter int FILTER_LEN = 4) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic mode_50hz,
    input wire logic mode_24h,
    input wire logic load,
    input wire logic busy,
    input wire logic tick_seen,
    input wire logic [5:0] load_ticks,
    input wire logic [5:0] hours_count,
    input wire logic [5:0] seconds_count,
    input wire logic [5:0] ticks_count
);
    default clocking dc @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_fix12;
        hours_count == 6'h00 ##1 hours_count == 6'h01;
    endsequence
    a_tick_pulse: assert property (tick_seen |=> !tick_seen)
        else $error("tick pulse long");
    a_tick_bump: assert property (tick_seen && !$past(busy | load)
        |=> ticks_count == $past(ticks_count) + 6'h01) else $error("no bump");
    a_tick_wrap:
        assert property (ticks_count == (mode_50hz ? 6'h32 : 6'h3c)
        |=> ticks_count == 6'h00) else $error("ticks kept");
    a_sec_carry:
        assert property (!$past(load) && $changed(seconds_count)
        |-> ticks_count == 6'h00) else $error("seconds moved");
    a_hours_24: assert property (mode_24h && hours_count == 6'h18
        |=> hours_count == 6'h00) else $error("hours kept");
    a_hours_12: assert property (!mode_24h && hours_count == 6'h0d
        |=> s_fix12) else $error("hours not one");
    a_load_take: assert property (load && !busy
        |=> ticks_count == $past(load_ticks)) else $error("load missed");
    a_busy_bound: assert property ($rose(busy) |-> ##[1:12] !busy)
        else $error("update long");
endmodule
bind line_frequency_time_of_day_counter tod_props #(
    .FILTER_LEN(FILTER_LEN)
) u_props (
    .clk(clk),
    .rst_n(rst_n),
    .mode_50hz(mode_50hz),
    .mode_24h(mode_24h),
    .load(load),
    .busy(busy),
    .tick_seen(tick_seen),
    .load_ticks(load_ticks),
    .hours_count(hours_count),
    .seconds_count(seconds_count),
    .ticks_count(ticks_count)
);

/* verification/line_frequency_time_of_day_counter_tb.sv */
// self-checking bench for the time of day counter
`timescale 1ns/1ps
module line_frequency_time_of_day_counter_tb;
    logic clk, rst_n, line_in, mode_50hz, mode_24h, load, busy, tick_seen;
    logic [5:0] load_hours, load_minutes, load_seconds, load_ticks;
    logic [5:0] hours_count, minutes_count, seconds_count, ticks_count;
    wire [23:0] now = {hours_count, minutes_count, seconds_count, ticks_count};
    int err_total = 0, checked = 0, cyc = 0;
    mains_src src (.clk(clk), .line_out(line_in));
    line_frequency_time_of_day_counter DUT (
        .clk(clk),
        .rst_n(rst_n),
        .line_in(line_in),
        .mode_50hz(mode_50hz),
        .mode_24h(mode_24h),
        .load(load),
        .load_hours(load_hours),
        .load_minutes(load_minutes),
        .load_seconds(load_seconds),
        .load_ticks(load_ticks),
        .hours_count(hours_count),
        .minutes_count(minutes_count),
        .seconds_count(seconds_count),
        .ticks_count(ticks_count),
        .busy(busy),
        .tick_seen(tick_seen)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            err_total++;
            wrap_up();
        end
    end
    task automatic chk(input logic [23:0] want);
        checked++;
        if (now !== want || busy !== 1'b0) begin
            err_total++;
            $display("MISMATCH %0t got %h want %h busy %b",
                $time, now, want, busy);
        end
    endtask
    task automatic step(input logic [23:0] start, input bit bounce);
        @(negedge clk);
        {load_hours, load_minutes, load_seconds, load_ticks} = start;
        load = 1'b1;
        @(negedge clk);
        load = 1'b0;
        src.mains_cycle(bounce);
        for (int n = 0; n < 50 && busy !== 1'b0; n++) @(negedge clk);
    endtask
    task automatic t_roll12();
        // 12:59:59:59 to 1:00:00:00
        step(24'h33_befb, 1'b0);
        chk(24'h04_0000);
        $display("roll12 end");
    endtask
    task automatic t_roll24();
        // 23:59:59:59 to 0:00:00:00
        mode_24h = 1'b1;
        step(24'h5f_befb, 1'b0);
        chk(24'h00_0000);
        $display("roll24 end");
    endtask
    task automatic t_50hz();
        // 5:10:20 ticks 48 then 49, bounce filtered
        mode_50hz = 1'b1;
        step(24'h14_a530, 1'b1);
        chk(24'h14_a531);
        step(24'h14_a531, 1'b0);
        chk(24'h14_a540);
        $display("50hz end");
    endtask
    task automatic t_burst();
        // 23:59:59:49 at 50 Hz, second edge arrives during the carry
        @(negedge clk);
        {load_hours, load_minutes, load_seconds, load_ticks} = 24'h5f_bef1;
        load = 1'b1;
        @(negedge clk);
        load = 1'b0;
        src.mains_burst();
        chk(24'h00_0001);
        $display("burst end");
    endtask
    task automatic t_reset();
        // reset in mid-run clears a running time
        @(negedge clk);
        rst_n = 1'b0;
        @(negedge clk);
        chk(24'h00_0000);
        rst_n = 1'b1;
        $display("reset end");
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        {rst_n, load, mode_50hz, mode_24h} = 4'h0;
        {load_hours, load_minutes, load_seconds, load_ticks} = 24'h00_0000;
        repeat (2) @(negedge clk);
        chk(24'h00_0000);
        rst_n = 1'b1;
        t_roll12();
        t_roll24();
        t_50hz();
        t_burst();
        t_reset();
        wrap_up();
    end
endmodule
